/* File: rtl/xie_core.sv */
// extended instruction and emulation-mode unit of the 16-bit core
// assumes one clock, synchronous reset, and a sequencer that moves
// memory words in and out through the mem and operand registers
//
// Implementation choices: the address map and the strobed register port.
`default_nettype none
module xie_core (
  input wire logic clk,
  input wire logic rstn,
  input wire xie_pkg::xie_bus_t bus,
  output logic [15:0] rdata,
  output logic mode_native,
  output xie_pkg::xie_addr_t addr_out,
  output xie_pkg::xie_cop_t cop
);

  ////////////////////////////////////////////////////////////////////
  // functions

  // length code 0..15 gives a mask of 1..16 ones
  function automatic logic [15:0] fmask(input logic [3:0] len);
    logic [16:0] one;
    one = 17'h00001 << ({1'b0, len} + 5'h01);
    fmask = 16'(one - 17'h00001);
  endfunction : fmask

  // one decimal digit with carry or borrow
  function automatic logic [4:0] bcd_digit(
    input logic [3:0] a,
    input logic [3:0] b,
    input logic ci,
    input logic sub
  );
    logic [5:0] s;
    s = 6'h00;
    if (sub) begin
      s = {2'b00, a} - {2'b00, b} - {5'h00, ci};
      if (s[5])
        bcd_digit = {1'b1, 4'(s[3:0] + 4'hA)};
      else
        bcd_digit = {1'b0, s[3:0]};
    end else begin
      s = {2'b00, a} + {2'b00, b} + {5'h00, ci};
      if (s > 6'h09)
        bcd_digit = {1'b1, 4'(s[3:0] + 4'h6)};
      else
        bcd_digit = {1'b0, s[3:0]};
    end
  endfunction : bcd_digit

  // legacy byte register code to native byte register id
  function automatic logic [3:0] emu_map(input logic [2:0] code);
    case (code)
      3'h0: emu_map = 4'h5; // B -> count high
      3'h1: emu_map = 4'h1; // C -> count low
      3'h2: emu_map = 4'h6; // D -> data high
      3'h3: emu_map = 4'h2; // E -> data low
      3'h4: emu_map = 4'h7; // H -> base high
      3'h5: emu_map = 4'h3; // L -> base low
      3'h6: emu_map = xie_pkg::NAT_MEM;
      default: emu_map = 4'h0; // A -> accumulator low
    endcase
  endfunction : emu_map

  ////////////////////////////////////////////////////////////////////
  // registers

  logic [15:0] acc_r, acc_nxt, src_r, src_nxt, dst_r, dst_nxt;
  logic [3:0] ofs_r, ofs_nxt, len_r, len_nxt;
  logic [15:0] mlo_r, mlo_nxt, mhi_r, mhi_nxt, oper_r, oper_nxt;
  logic [15:0] psw_r, psw_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic first_r, first_nxt;
  logic [15:0] ps_r, ps_nxt, pc_r, pc_nxt, ds0_r, ds0_nxt;
  logic [15:0] ds1_r, ds1_nxt, bp_r, bp_nxt, sp_r, sp_nxt;
  logic [15:0] fps_r, fps_nxt, fpc_r, fpc_nxt, fpsw_r, fpsw_nxt;
  logic [7:0] vec_r, vec_nxt, opc_r, opc_nxt;
  logic [2:0] lsel_r, lsel_nxt;
  logic rep_r, rep_nxt, err_r, err_nxt;
  logic [15:0] rd_val;

  ////////////////////////////////////////////////////////////////////
  // decode

  wire logic md = psw_r[xie_pkg::F_MD];
  wire logic cy = psw_r[xie_pkg::F_CY];
  wire logic wr_cmd = bus.wr && (bus.addr == xie_pkg::A_CMD);
  wire logic [4:0] cmd = wr_cmd ? bus.wdata[4:0] : 5'h00;
  // segment and index writes are locked out while emulating
  wire logic emu_lock = !md && (bus.addr == xie_pkg::A_SRC ||
    bus.addr == xie_pkg::A_DST || bus.addr == xie_pkg::A_PS ||
    bus.addr == xie_pkg::A_DS0 || bus.addr == xie_pkg::A_DS1);
  wire logic wr_ok = bus.wr && !emu_lock;

  // bit field window spans two words so a field may straddle them
  wire logic [31:0] win = {mhi_r, mlo_r};
  wire logic [15:0] fm = fmask(len_r);
  wire logic [31:0] m32 = {16'h0000, fm} << ofs_r;
  wire logic [31:0] placed = (win & ~m32) |
    (({16'h0000, acc_r} << ofs_r) & m32);
  wire logic [31:0] shifted = win >> ofs_r;
  wire logic [15:0] pulled = shifted[15:0] & fm;
  wire logic [4:0] fsum = {1'b0, ofs_r} + {1'b0, len_r} + 5'h01;
  wire logic [15:0] word_step = fsum[4] ? 16'h0002 : 16'h0000;

  // bcd byte step: destination byte in mem low, source byte in operand
  wire logic bsub = (cmd != xie_pkg::C_BADD);
  wire logic bcin = first_r ? 1'b0 : cy;
  wire logic [4:0] dlo = bcd_digit(mlo_r[3:0], oper_r[3:0], bcin, bsub);
  wire logic [4:0] dhi = bcd_digit(mlo_r[7:4], oper_r[7:4], dlo[4], bsub);
  wire logic [7:0] bres = {dhi[3:0], dlo[3:0]};
  wire logic bz = (bres == 8'h00) && (first_r || psw_r[xie_pkg::F_Z]);
  wire logic bcd_done = (cnt_r == 8'h00);
  wire logic [7:0] cnt_dec = (cnt_r <= xie_pkg::BCD_STEP) ? 8'h00 :
    8'(cnt_r - xie_pkg::BCD_STEP);

  // single bit select
  wire logic [15:0] bsel = 16'h0001 << ofs_r;
  wire logic bit_now = |(oper_r & bsel);

  // float escape opcodes: two families
  wire logic fpo_hit = (bus.wdata[7:3] == xie_pkg::FPO1_TOP) ||
    (bus.wdata[7:1] == xie_pkg::FPO2_TOP);
  wire logic wr_opc = wr_ok && (bus.addr == xie_pkg::A_OPC);

  // vector table entry address and class
  wire logic [19:0] vec_addr = {10'h000, vec_r, 2'b00};
  wire logic [1:0] vec_cls = (vec_r <= xie_pkg::VEC_FIX_LAST) ? 2'h0 :
    (vec_r <= xie_pkg::VEC_RSV_LAST) ? 2'h1 : 2'h2;

  // mode switch commands and their guards
  wire logic take_emu = (cmd == xie_pkg::C_EMU) && md;
  wire logic take_call_native_handler = (cmd == xie_pkg::C_CALL_NATIVE_HANDLER) && !md;
  wire logic take_intr = (cmd == xie_pkg::C_INTR);
  wire logic take_vec = take_emu || take_call_native_handler || take_intr;
  wire logic take_ret = (cmd == xie_pkg::C_RETURN_FROM_INTERRUPT) ||
    ((cmd == xie_pkg::C_RETURN_FROM_EMULATION) && md);
  wire logic bad_mode = ((cmd == xie_pkg::C_EMU) && !md) ||
    ((cmd == xie_pkg::C_CALL_NATIVE_HANDLER) && md) ||
    ((cmd == xie_pkg::C_RETURN_FROM_EMULATION) && !md);
  wire logic bcd_cmd = (cmd == xie_pkg::C_BADD) ||
    (cmd == xie_pkg::C_BSUB) || (cmd == xie_pkg::C_BCMP);
  wire logic bad_cnt = wr_ok && (bus.addr == xie_pkg::A_CNT) &&
    (bus.wdata[7:0] == 8'h00 || bus.wdata[7:0] > xie_pkg::BCD_MAX);
  wire logic err_set = bad_mode || bad_cnt || (bcd_cmd && bcd_done) ||
    (bus.wr && emu_lock);
  wire logic err_clr = wr_ok && (bus.addr == xie_pkg::A_EXT) &&
    bus.wdata[xie_pkg::X_ERR];

  ////////////////////////////////////////////////////////////////////
  // next state

  // plain writes first, then the command that was written
  always_comb begin
    acc_nxt = acc_r;
    src_nxt = src_r;
    dst_nxt = dst_r;
    ofs_nxt = ofs_r;
    len_nxt = len_r;
    mlo_nxt = mlo_r;
    mhi_nxt = mhi_r;
    oper_nxt = oper_r;
    psw_nxt = psw_r;
    cnt_nxt = cnt_r;
    first_nxt = first_r;
    ps_nxt = ps_r;
    pc_nxt = pc_r;
    ds0_nxt = ds0_r;
    ds1_nxt = ds1_r;
    bp_nxt = bp_r;
    sp_nxt = sp_r;
    fps_nxt = fps_r;
    fpc_nxt = fpc_r;
    fpsw_nxt = fpsw_r;
    vec_nxt = vec_r;
    opc_nxt = opc_r;
    lsel_nxt = lsel_r;
    rep_nxt = rep_r;
    // set wins over clear for the sticky error
    err_nxt = err_set || (err_r && !err_clr);
    if (wr_ok) begin
      case (bus.addr)
        xie_pkg::A_ACC: acc_nxt = bus.wdata;
        xie_pkg::A_SRC: src_nxt = bus.wdata;
        xie_pkg::A_DST: dst_nxt = bus.wdata;
        xie_pkg::A_OFS: ofs_nxt = bus.wdata[3:0];
        xie_pkg::A_LEN: len_nxt = bus.wdata[3:0];
        xie_pkg::A_MLO: mlo_nxt = bus.wdata;
        xie_pkg::A_MHI: mhi_nxt = bus.wdata;
        xie_pkg::A_OPER: oper_nxt = bus.wdata;
        // upper status byte is hidden from emulated code
        xie_pkg::A_PSW: psw_nxt = md ? bus.wdata :
          {psw_r[15:8], bus.wdata[7:0]};
        xie_pkg::A_CNT: begin
          cnt_nxt = bad_cnt ? 8'h00 : bus.wdata[7:0];
          first_nxt = 1'b1;
        end
        xie_pkg::A_PS: ps_nxt = bus.wdata;
        xie_pkg::A_PC: pc_nxt = bus.wdata;
        xie_pkg::A_DS0: ds0_nxt = bus.wdata;
        xie_pkg::A_DS1: ds1_nxt = bus.wdata;
        xie_pkg::A_BP: bp_nxt = bus.wdata;
        xie_pkg::A_SP: sp_nxt = bus.wdata;
        xie_pkg::A_FPS: fps_nxt = bus.wdata;
        xie_pkg::A_FPC: fpc_nxt = bus.wdata;
        xie_pkg::A_FPSW: fpsw_nxt = bus.wdata;
        xie_pkg::A_VEC: vec_nxt = bus.wdata[7:0];
        xie_pkg::A_LSEL: lsel_nxt = bus.wdata[2:0];
        xie_pkg::A_OPC: opc_nxt = bus.wdata[7:0];
        default: ;
      endcase
    end
    case (cmd)
      xie_pkg::C_FPLACE: begin
        mlo_nxt = placed[15:0];
        mhi_nxt = placed[31:16];
        ofs_nxt = fsum[3:0];
        dst_nxt = dst_r + word_step;
      end
      xie_pkg::C_FPULL: begin
        acc_nxt = pulled;
        ofs_nxt = fsum[3:0];
        src_nxt = src_r + word_step;
      end
      xie_pkg::C_BADD, xie_pkg::C_BSUB, xie_pkg::C_BCMP: begin
        if (!bcd_done) begin
          // compare leaves the destination alone; flags, indices and count still update
          if (cmd != xie_pkg::C_BCMP)
            mlo_nxt = {mlo_r[15:8], bres};
          psw_nxt[xie_pkg::F_CY] = dhi[4];
          psw_nxt[xie_pkg::F_Z] = bz;
          src_nxt = src_r + 16'h0001;
          dst_nxt = dst_r + 16'h0001;
          cnt_nxt = cnt_dec;
          first_nxt = 1'b0;
        end
      end
      xie_pkg::C_ROTL: begin
        acc_nxt = {acc_r[15:4], oper_r[7:4]};
        oper_nxt = {oper_r[15:8], oper_r[3:0], acc_r[3:0]};
      end
      xie_pkg::C_ROTR: begin
        acc_nxt = {acc_r[15:4], oper_r[3:0]};
        oper_nxt = {oper_r[15:8], acc_r[3:0], oper_r[7:4]};
      end
      xie_pkg::C_BTST: psw_nxt[xie_pkg::F_Z] = !bit_now;
      xie_pkg::C_BSET: oper_nxt = oper_r | bsel;
      xie_pkg::C_BCLR: oper_nxt = oper_r & ~bsel;
      xie_pkg::C_BNOT: oper_nxt = oper_r ^ bsel;
      xie_pkg::C_REPEAT_WHILE_CARRY: rep_nxt = cy;
      xie_pkg::C_REPEAT_WHILE_NO_CARRY: rep_nxt = !cy;
      default: ;
    endcase
    // break style entry: push frame, load vector pair
    if (take_vec) begin
      fps_nxt = ps_r;
      fpc_nxt = pc_r;
      fpsw_nxt = psw_r;
      pc_nxt = mlo_r;
      ps_nxt = mhi_r;
      psw_nxt[xie_pkg::F_IE] = 1'b0;
      psw_nxt[xie_pkg::F_BRK] = 1'b0;
      psw_nxt[xie_pkg::F_MD] = !take_emu;
    end
    // return: pop frame, restored status carries the old mode
    if (take_ret) begin
      ps_nxt = fps_r;
      pc_nxt = fpc_r;
      psw_nxt = fpsw_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read mux

  always_comb begin
    case (bus.addr)
      xie_pkg::A_ACC: rd_val = acc_r;
      xie_pkg::A_SRC: rd_val = src_r;
      xie_pkg::A_DST: rd_val = dst_r;
      xie_pkg::A_OFS: rd_val = {12'h000, ofs_r};
      xie_pkg::A_LEN: rd_val = {12'h000, len_r};
      xie_pkg::A_MLO: rd_val = mlo_r;
      xie_pkg::A_MHI: rd_val = mhi_r;
      xie_pkg::A_OPER: rd_val = oper_r;
      xie_pkg::A_PSW: rd_val = psw_r;
      xie_pkg::A_CNT: rd_val = {8'h00, cnt_r};
      xie_pkg::A_PS: rd_val = ps_r;
      xie_pkg::A_PC: rd_val = pc_r;
      xie_pkg::A_DS0: rd_val = ds0_r;
      xie_pkg::A_DS1: rd_val = ds1_r;
      xie_pkg::A_BP: rd_val = bp_r;
      xie_pkg::A_SP: rd_val = sp_r;
      xie_pkg::A_FPS: rd_val = fps_r;
      xie_pkg::A_FPC: rd_val = fpc_r;
      xie_pkg::A_FPSW: rd_val = fpsw_r;
      xie_pkg::A_VEC: rd_val = {8'h00, vec_r};
      xie_pkg::A_VADR: rd_val = vec_addr[15:0];
      xie_pkg::A_LSEL: rd_val = {12'h000, emu_map(lsel_r)};
      xie_pkg::A_OPC: rd_val = {8'h00, opc_r};
      xie_pkg::A_EXT: rd_val = {10'h000, vec_cls, cop.req, err_r,
        bcd_done, rep_r};
      default: rd_val = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // state and outputs

  // reset forces native mode whatever ran before
  always_ff @(posedge clk) begin
    if (!rstn) begin
      psw_r <= xie_pkg::PSW_RST;
      fpsw_r <= xie_pkg::PSW_RST;
      cnt_r <= 8'h00;
      first_r <= 1'b1;
      rep_r <= 1'b0;
      err_r <= 1'b0;
      rdata <= 16'h0000;
    end else begin
      psw_r <= psw_nxt;
      fpsw_r <= fpsw_nxt;
      cnt_r <= cnt_nxt;
      first_r <= first_nxt;
      rep_r <= rep_nxt;
      err_r <= err_nxt;
      // read data stands only in the cycle after the strobe
      rdata <= bus.rd ? rd_val : 16'h0000;
    end
  end

  // datapath words
  always_ff @(posedge clk) begin
    if (!rstn) begin
      {acc_r, src_r, dst_r, mlo_r, mhi_r, oper_r} <= '0;
      {ps_r, pc_r, ds0_r, ds1_r, bp_r, sp_r, fps_r, fpc_r} <= '0;
      {ofs_r, len_r, vec_r, opc_r, lsel_r} <= '0;
    end else begin
      {acc_r, src_r, dst_r, mlo_r, mhi_r, oper_r} <=
        {acc_nxt, src_nxt, dst_nxt, mlo_nxt, mhi_nxt, oper_nxt};
      {ps_r, pc_r, ds0_r, ds1_r, bp_r, sp_r, fps_r, fpc_r} <=
        {ps_nxt, pc_nxt, ds0_nxt, ds1_nxt, bp_nxt, sp_nxt, fps_nxt, fpc_nxt};
      {ofs_r, len_r, vec_r, opc_r, lsel_r} <=
        {ofs_nxt, len_nxt, vec_nxt, opc_nxt, lsel_nxt};
    end
  end

  // address outputs are registered from the next-state values, in step with the registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      addr_out <= '0;
      cop <= '0;
      mode_native <= 1'b1;
    end else begin
      mode_native <= psw_nxt[xie_pkg::F_MD];
      addr_out.fetch_addr <= 20'({ps_nxt, 4'h0}) + {4'h0, pc_nxt};
      addr_out.data_seg <= psw_nxt[xie_pkg::F_MD] ? ds1_nxt : ds0_nxt;
      addr_out.stack_ptr <= psw_nxt[xie_pkg::F_MD] ? sp_nxt : bp_nxt;
      // escape: one-cycle request carrying the effective address
      cop.req <= wr_opc && fpo_hit;
      if (wr_opc && fpo_hit) begin
        cop.addr <= 20'({ds0_r, 4'h0}) + {4'h0, oper_r};
        cop.opcode <= bus.wdata[7:0];
      end
    end
  end

endmodule : xie_core
`default_nettype wire

/* File: rtl/xie_pkg.sv */
// Function
// - bit fields of 1 to 16 bits, placed at any bit of memory
// - field place copies accumulator field to destination, then advances
// - field pull loads field right-justified zero-filled, then advances
// - bit offset 0 selects bit 0, 15 selects bit 15
// - bcd strings hold 1 to 254 digits per instruction
// - bcd source at source index, destination at destination index
// - zero and carry follow result; odd counts rely on top digit
// - digit rotate moves low nibble of accumulator low byte through operand
// - four ops test, set, clear or complement one operand bit
// - carry repeat prefixes use carry flag as termination condition
// - float escape detected, address formed, coprocessor cycle requested
// - mode flag one means native, zero means emulation
// - enter emulation breaks, then clears mode flag after push
// - emulation maps legacy registers, hides segments, indexes, high bytes
// - emulation uses base pointer as its stack pointer
// - emulation fetch uses program segment, data uses data segment 0
// - interrupt in emulation pushes frame, sets mode flag, return resumes
// - reset always leaves the core in native mode
// - call native acts as break, saved status shows emulation
// - return from emulation pops frame; nested entry refused
// - 256-entry vector table at address zero, classes by number
// - vector low word loads pc, next word loads program segment
//
// constants and carriers for the extended instruction unit
// assumes the core sequencer drives the register port on the same clock
`default_nettype none
package xie_pkg;
  // register indices on the plain register port
  localparam logic [4:0] A_CMD = 5'h00;
  localparam logic [4:0] A_ACC = 5'h01;
  localparam logic [4:0] A_SRC = 5'h02;
  localparam logic [4:0] A_DST = 5'h03;
  localparam logic [4:0] A_OFS = 5'h04;
  localparam logic [4:0] A_LEN = 5'h05;
  localparam logic [4:0] A_MLO = 5'h06;
  localparam logic [4:0] A_MHI = 5'h07;
  localparam logic [4:0] A_OPER = 5'h08;
  localparam logic [4:0] A_PSW = 5'h09;
  localparam logic [4:0] A_CNT = 5'h0A;
  localparam logic [4:0] A_PS = 5'h0B;
  localparam logic [4:0] A_PC = 5'h0C;
  localparam logic [4:0] A_DS0 = 5'h0D;
  localparam logic [4:0] A_DS1 = 5'h0E;
  localparam logic [4:0] A_BP = 5'h0F;
  localparam logic [4:0] A_SP = 5'h10;
  localparam logic [4:0] A_FPS = 5'h11;
  localparam logic [4:0] A_FPC = 5'h12;
  localparam logic [4:0] A_FPSW = 5'h13;
  localparam logic [4:0] A_VEC = 5'h14;
  localparam logic [4:0] A_VADR = 5'h15;
  localparam logic [4:0] A_LSEL = 5'h16;
  localparam logic [4:0] A_OPC = 5'h17;
  localparam logic [4:0] A_EXT = 5'h18;
  // command codes written to A_CMD
  localparam logic [4:0] C_FPLACE = 5'h01;
  localparam logic [4:0] C_FPULL = 5'h02;
  localparam logic [4:0] C_BADD = 5'h03;
  localparam logic [4:0] C_BSUB = 5'h04;
  localparam logic [4:0] C_BCMP = 5'h05;
  localparam logic [4:0] C_ROTL = 5'h06;
  localparam logic [4:0] C_ROTR = 5'h07;
  localparam logic [4:0] C_BTST = 5'h08;
  localparam logic [4:0] C_BSET = 5'h09;
  localparam logic [4:0] C_BCLR = 5'h0A;
  localparam logic [4:0] C_BNOT = 5'h0B;
  localparam logic [4:0] C_REPEAT_WHILE_CARRY = 5'h0C;
  localparam logic [4:0] C_REPEAT_WHILE_NO_CARRY = 5'h0D;
  localparam logic [4:0] C_EMU = 5'h0E;
  localparam logic [4:0] C_CALL_NATIVE_HANDLER = 5'h0F;
  localparam logic [4:0] C_RETURN_FROM_EMULATION = 5'h10;
  localparam logic [4:0] C_INTR = 5'h11;
  localparam logic [4:0] C_RETURN_FROM_INTERRUPT = 5'h12;
  // status word bit positions
  localparam int F_CY = 0;
  localparam int F_Z = 6;
  localparam int F_BRK = 8;
  localparam int F_IE = 9;
  localparam int F_MD = 15;
  localparam logic [15:0] PSW_RST = 16'h8000;
  // extension status bit positions
  localparam int X_REP = 0;
  localparam int X_DONE = 1;
  localparam int X_ERR = 2;
  localparam int X_FPO = 3;
  localparam int X_CLS = 4;
  // limits and encodings
  localparam logic [7:0] BCD_MAX = 8'hFE;
  localparam logic [7:0] BCD_STEP = 8'h02;
  localparam logic [4:0] FPO1_TOP = 5'h1B;
  localparam logic [6:0] FPO2_TOP = 7'h33;
  localparam logic [7:0] VEC_FIX_LAST = 8'h05;
  localparam logic [7:0] VEC_RSV_LAST = 8'h1F;
  localparam logic [3:0] NAT_MEM = 4'h8;

  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } xie_bus_t;

  typedef struct packed {
    logic [19:0] fetch_addr;
    logic [15:0] data_seg;
    logic [15:0] stack_ptr;
  } xie_addr_t;

  typedef struct packed {
    logic req;
    logic [19:0] addr;
    logic [7:0] opcode;
  } xie_cop_t;
endpackage : xie_pkg
`default_nettype wire

/* File: sim/xie_core_checker.sv */
// port assertions for the extended instruction unit
// bound to xie_core; one clock, synchronous active-low reset
`default_nettype none
module xie_core_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire xie_pkg::xie_bus_t bus,
  input wire logic [15:0] rdata,
  input wire logic mode_native,
  input wire xie_pkg::xie_addr_t addr_out,
  input wire xie_pkg::xie_cop_t cop
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  //////////////////////////////////////////////////////////////
  // read data must not linger, or a stale word looks like a read
  a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 16'h0000)
    else $error("read data present without a read");
  // escape request is a single-cycle pulse
  a_req_pulse: assert property (cop.req |=> !cop.req)
    else $error("escape request wider than one cycle");
  a_req_cause: assert property (cop.req |-> $past(bus.wr) &&
    $past(bus.addr) == xie_pkg::A_OPC &&
    ($past(bus.wdata[7:3]) == xie_pkg::FPO1_TOP ||
    $past(bus.wdata[7:1]) == xie_pkg::FPO2_TOP))
    else $error("escape request without an escape opcode");
  a_esc_opcode: assert property (cop.req |->
    cop.opcode == $past(bus.wdata[7:0]))
    else $error("escape opcode differs from written code");
  // the coprocessor may latch late, so address must hold
  a_addr_hold: assert property (!cop.req |->
    $stable(cop.addr) && $stable(cop.opcode))
    else $error("escape address moved without a request");
  a_mode_cause: assert property ($changed(mode_native) |->
    $past(bus.wr))
    else $error("mode changed without a write");
  a_reset_native: assert property (disable iff (1'b0)
    !rstn |=> mode_native)
    else $error("reset did not give native mode");
  a_seg_frozen: assert property (!mode_native &&
    $past(!mode_native) && $past(!mode_native, 2) |->
    $stable(addr_out.data_seg))
    else $error("data segment moved during emulation");
endmodule : xie_core_checker

bind xie_core xie_core_checker u_chk (.clk(clk), .rstn(rstn), .bus(bus),
  .rdata(rdata), .mode_native(mode_native), .addr_out(addr_out),
  .cop(cop));
`default_nettype wire

/* File: sim/xie_fpu_model.sv */
// coprocessor stand-in on the escape request lines
// assumes the request is one cycle long and the address holds after it
`default_nettype none
module xie_fpu_model (
  input wire logic clk,
  input wire logic rstn,
  input wire xie_pkg::xie_cop_t cop,
  output logic [19:0] lat_addr,
  output logic [7:0] lat_op,
  output logic [7:0] lat_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  //////////////////////////////////////////////////////////////
  // latch address and opcode on each request, count them
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lat_addr <= 20'h00000;
      lat_op <= 8'h00;
      lat_cnt <= 8'h00;
    end else if (cop.req) begin
      lat_addr <= cop.addr;
      lat_op <= cop.opcode;
      lat_cnt <= lat_cnt + 8'h01;
    end
  end
endmodule : xie_fpu_model
`default_nettype wire

/* File: sim/tb.sv */
// self-checking bench for the extended instruction unit
// plays the core sequencer on the register port; coprocessor modelled
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  xie_pkg::xie_bus_t bus = '0;
  logic [15:0] rdata;
  logic mode_native;
  xie_pkg::xie_addr_t addr_out;
  xie_pkg::xie_cop_t cop;
  logic [19:0] lat_addr;
  logic [7:0] lat_op;
  logic [7:0] lat_cnt;
  int err_total = 0;
  int checks = 0;

  always #50 clk = ~clk;

  xie_core u_dut (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata),
    .mode_native(mode_native), .addr_out(addr_out), .cop(cop));
  xie_fpu_model u_fpu (.clk(clk), .rstn(rstn), .cop(cop),
    .lat_addr(lat_addr), .lat_op(lat_op), .lat_cnt(lat_cnt));
  //////////////////////////////////////////////////////////////
  // one strobe per call; released at the clock edge, returns 1 ns later so calls chain
  task automatic drive(input logic [4:0] a, input logic [15:0] d,
    input logic w, input logic r);
    bus <= xie_pkg::xie_bus_t'{a, d, w, r};
    @(posedge clk);
    bus <= '0;
    #1;
  endtask : drive
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    drive(a, d, 1'b1, 1'b0);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [15:0] exp,
    input logic [15:0] m = 16'hFFFF);
    drive(a, 16'h0000, 1'b0, 1'b1);
    chk({4'h0, rdata & m}, {4'h0, exp});
  endtask : rd
  task automatic cmd(input logic [4:0] c);
    wr(xie_pkg::A_CMD, {11'h000, c});
  endtask : cmd
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task automatic conclude();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  //////////////////////////////////////////////////////////////
  // field crossing the word boundary, full 16-bit length
  task automatic t_field();
    wr(xie_pkg::A_MLO, 16'h1234);
    wr(xie_pkg::A_MHI, 16'hABCD);
    wr(xie_pkg::A_OFS, 16'h000C);
    wr(xie_pkg::A_LEN, 16'h0007);
    cmd(xie_pkg::C_FPULL);
    rd(xie_pkg::A_ACC, 16'h00D1);
    rd(xie_pkg::A_OFS, 16'h0004);
    rd(xie_pkg::A_SRC, 16'h0002);
    wr(xie_pkg::A_LEN, 16'h000F);
    wr(xie_pkg::A_ACC, 16'h5A5A);
    cmd(xie_pkg::C_FPLACE);
    rd(xie_pkg::A_MLO, 16'hA5A4);
    rd(xie_pkg::A_MHI, 16'hABC5);
    rd(xie_pkg::A_DST, 16'h0002);
  endtask : t_field
  // decimal carry, exhausted count, illegal count, borrow, compare
  task automatic t_bcd();
    wr(xie_pkg::A_CNT, 16'h0002);
    wr(xie_pkg::A_MLO, 16'h0099);
    wr(xie_pkg::A_OPER, 16'h0001);
    cmd(xie_pkg::C_BADD);
    rd(xie_pkg::A_MLO, 16'h0000);
    rd(xie_pkg::A_PSW, 16'h0041, 16'h0041);
    rd(xie_pkg::A_SRC, 16'h0003);
    rd(xie_pkg::A_DST, 16'h0003);
    rd(xie_pkg::A_EXT, 16'h0002, 16'h0006);
    cmd(xie_pkg::C_BSUB);
    rd(xie_pkg::A_EXT, 16'h0004, 16'h0004);
    wr(xie_pkg::A_EXT, 16'h0004);
    wr(xie_pkg::A_CNT, 16'h00FF);
    rd(xie_pkg::A_EXT, 16'h0004, 16'h0004);
    wr(xie_pkg::A_CNT, 16'h00FE);
    wr(xie_pkg::A_MLO, 16'h0010);
    wr(xie_pkg::A_OPER, 16'h0025);
    cmd(xie_pkg::C_BSUB);
    rd(xie_pkg::A_MLO, 16'h0085);
    rd(xie_pkg::A_PSW, 16'h0001, 16'h0041);
    rd(xie_pkg::A_CNT, 16'h00FC);
    wr(xie_pkg::A_OPER, 16'h0085);
    cmd(xie_pkg::C_BCMP);
    rd(xie_pkg::A_MLO, 16'h0085);
    rd(xie_pkg::A_PSW, 16'h0001, 16'h0041);
  endtask : t_bcd
  // digit rotation, top bit ops, carry repeat prefixes
  task automatic t_bits();
    wr(xie_pkg::A_ACC, 16'h0005);
    wr(xie_pkg::A_OPER, 16'h0037);
    cmd(xie_pkg::C_ROTL);
    rd(xie_pkg::A_ACC, 16'h0003);
    rd(xie_pkg::A_OPER, 16'h0075);
    cmd(xie_pkg::C_ROTR);
    rd(xie_pkg::A_ACC, 16'h0005);
    rd(xie_pkg::A_OPER, 16'h0037);
    wr(xie_pkg::A_OPER, 16'h0000);
    wr(xie_pkg::A_OFS, 16'h000F);
    cmd(xie_pkg::C_BSET);
    rd(xie_pkg::A_OPER, 16'h8000);
    cmd(xie_pkg::C_BTST);
    rd(xie_pkg::A_PSW, 16'h0000, 16'h0040);
    cmd(xie_pkg::C_BCLR);
    rd(xie_pkg::A_OPER, 16'h0000);
    cmd(xie_pkg::C_BTST);
    rd(xie_pkg::A_PSW, 16'h0040, 16'h0040);
    cmd(xie_pkg::C_BNOT);
    rd(xie_pkg::A_OPER, 16'h8000);
    wr(xie_pkg::A_PSW, 16'h8001);
    cmd(xie_pkg::C_REPEAT_WHILE_CARRY);
    rd(xie_pkg::A_EXT, 16'h0001, 16'h0001);
    cmd(xie_pkg::C_REPEAT_WHILE_NO_CARRY);
    rd(xie_pkg::A_EXT, 16'h0000, 16'h0001);
  endtask : t_bits
  // escape codes from both groups; a plain code must not request
  task automatic t_escape();
    wr(xie_pkg::A_DS0, 16'h1000);
    wr(xie_pkg::A_OPER, 16'h0234);
    wr(xie_pkg::A_OPC, 16'h00D9);
    idle(1);
    chk(lat_addr, 20'h10234);
    wr(xie_pkg::A_OPC, 16'h0090);
    wr(xie_pkg::A_OPC, 16'h0066);
    idle(1);
    chk({12'h000, lat_op}, 20'h00066);
    chk({12'h000, lat_cnt}, 20'h00002);
  endtask : t_escape
  // enter, refuse, nest, call native, interrupt, return, reset
  task automatic t_emu();
    wr(xie_pkg::A_PS, 16'h2000);
    wr(xie_pkg::A_PC, 16'h0100);
    wr(xie_pkg::A_DS1, 16'h3000);
    wr(xie_pkg::A_BP, 16'h0500);
    wr(xie_pkg::A_SP, 16'h0700);
    wr(xie_pkg::A_MLO, 16'h0040);
    wr(xie_pkg::A_MHI, 16'h4000);
    idle(1);
    chk({4'h0, addr_out.stack_ptr}, 20'h00700);
    cmd(xie_pkg::C_EMU);
    idle(1);
    chk({19'h0, mode_native}, 20'h00000);
    chk({4'h0, addr_out.data_seg}, 20'h01000);
    chk({4'h0, addr_out.stack_ptr}, 20'h00500);
    chk(addr_out.fetch_addr, 20'h40040);
    rd(xie_pkg::A_FPSW, 16'h8000, 16'h8000);
    rd(xie_pkg::A_FPS, 16'h2000);
    wr(xie_pkg::A_EXT, 16'h0004);
    wr(xie_pkg::A_DS0, 16'h5555);
    rd(xie_pkg::A_EXT, 16'h0004, 16'h0004);
    chk({4'h0, addr_out.data_seg}, 20'h01000);
    wr(xie_pkg::A_LSEL, 16'h0007);
    rd(xie_pkg::A_LSEL, 16'h0000, 16'h000F);
    wr(xie_pkg::A_LSEL, 16'h0000);
    rd(xie_pkg::A_LSEL, 16'h0005, 16'h000F);
    wr(xie_pkg::A_EXT, 16'h0004);
    cmd(xie_pkg::C_EMU);
    rd(xie_pkg::A_EXT, 16'h0004, 16'h0004);
    wr(xie_pkg::A_MHI, 16'h6000);
    cmd(xie_pkg::C_CALL_NATIVE_HANDLER);
    rd(xie_pkg::A_FPSW, 16'h0000, 16'h8000);
    chk({19'h0, mode_native}, 20'h00001);
    cmd(xie_pkg::C_RETURN_FROM_INTERRUPT);
    idle(1);
    chk({19'h0, mode_native}, 20'h00000);
    chk(addr_out.fetch_addr, 20'h40040);
    cmd(xie_pkg::C_INTR);
    rd(xie_pkg::A_FPSW, 16'h0000, 16'h8000);
    chk({19'h0, mode_native}, 20'h00001);
    cmd(xie_pkg::C_RETURN_FROM_EMULATION);
    idle(1);
    chk({19'h0, mode_native}, 20'h00000);
    rstn <= 1'b0;
    idle(3);
    rstn <= 1'b1;
    idle(1);
    chk({19'h0, mode_native}, 20'h00001);
    rd(xie_pkg::A_PSW, xie_pkg::PSW_RST);
  endtask : t_emu
  // vector table entry address and class at each boundary
  task automatic t_vector();
    logic [7:0] v [5] = '{8'h05, 8'h06, 8'h1F, 8'h20, 8'hFF};
    logic [1:0] c [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
    for (int i = 0; i < 5; i++) begin
      wr(xie_pkg::A_VEC, {8'h00, v[i]});
      rd(xie_pkg::A_VADR, {6'h00, v[i], 2'h0});
      rd(xie_pkg::A_EXT, {10'h000, c[i], 4'h0}, 16'h0030);
    end
  endtask : t_vector
  //////////////////////////////////////////////////////////////
  // reset for five cycles, then the scenarios in turn
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    idle(1);
    chk({19'h0, mode_native}, 20'h00001);
    rd(xie_pkg::A_PSW, xie_pkg::PSW_RST);
    t_field();
    t_bcd();
    t_bits();
    t_escape();
    t_emu();
    t_vector();
    conclude();
  end
  // guard against a hung run
  initial begin
    #2000000;
    err_total++;
    conclude();
  end
endmodule : tb
`default_nettype wire
